// ===== pio_ports.sv
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// [RQ1] 87 pins, each direction set independently
// [RQ2] one pull-up bit per four pins
// [RQ3] input-only pin: no pull-up, no direction
// [RQ4] peripheral output drives pin whatever direction
// [RQ5] software: peripheral inputs need input direction
// [RQ6] each direction bit maps to one pin
// [RQ7] bus pins' direction locked in external modes
// [RQ8] port bit: output latch plus pin readback
// [RQ9] bus pins' latch locked in external modes
// [RQ10] pull-up attaches only to input pins
// [RQ11] low ports' pull-ups inert in external modes
// [RQ12] port one read: pin if input, else latch
// [RQ13] read-select set: port one reads latch
// [RQ14] read-select works only for 8-bit bus
// [RQ15] direction resets to zero, meaning input
// [RQ16] other ports: pin if input, else latch
module pio_ports (
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // mode and bus straps from pins
  input  wire logic [1:0]      proc_mode,
  input  wire logic            bus_8bit,
  input  wire logic            p1_mux_all,
  // on-chip peripherals, same clock
  input  wire logic [87:0]     periph_oe,
  input  wire logic [87:0]     periph_out,
  // pads
  input  wire logic [87:0]     pin_in,
  output pio_pkg::pio_pad_s    pad
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [87:0]       dir_q,  dir_d;
  logic [87:0]       lat_q,  lat_d;
  logic [21:0]       pu_q,   pu_d;
  logic              pctl_q, pctl_d;
  logic              rdy_q,  rdy_d;
  logic              err_q,  err_d;
  logic [31:0]       rdat_q, rdat_d;
  pio_pkg::pio_pad_s pad_q,  pad_d;
  logic [87:0]       pin_s1_q, pin_s2_q;
  logic [1:0]        mode_s1_q, mode_s2_q;
  logic              b8_s1_q, b8_s2_q, mux_s1_q, mux_s2_q;

  logic              ext;
  logic              p1_sel;
  logic              acc;
  logic              wr_en;
  logic [3:0]        idx;
  logic              in_dir, in_dat;
  logic [87:0]       lock;

  assign prdata  = rdat_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign pad     = pad_q;

  // ****************************************************************
  // synchronisers for pin-side inputs
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q  <= 88'h0;
      pin_s2_q  <= 88'h0;
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      b8_s1_q   <= 1'b0;
      b8_s2_q   <= 1'b0;
      mux_s1_q  <= 1'b0;
      mux_s2_q  <= 1'b0;
    end else if (ce) begin
      pin_s1_q  <= pin_in;
      pin_s2_q  <= pin_s1_q;
      mode_s1_q <= proc_mode;
      mode_s2_q <= mode_s1_q;
      b8_s1_q   <= bus_8bit;
      b8_s2_q   <= b8_s1_q;
      mux_s1_q  <= p1_mux_all;
      mux_s2_q  <= mux_s1_q;
    end
  end

  assign ext    = (mode_s2_q != pio_pkg::MODE_SINGLE);
  // read-select only counts on an 8-bit multiplexed external bus
  assign p1_sel = pctl_q && ext && b8_s2_q && mux_s2_q; // RQ14
  assign lock   = ext ? pio_pkg::BUS_LOCK_MASK : 88'h0;

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign acc    = psel && penable;
  assign wr_en  = acc && rdy_q && pwrite;
  assign idx    = paddr[5:2];
  assign in_dir = (paddr[11:6] == pio_pkg::DIR_BASE[11:6]) && (idx < 4'hB);
  assign in_dat = (paddr[11:6] == pio_pkg::DATA_BASE[11:6]) && (idx < 4'hB);

  // read value of one port: pin level for inputs, latch for outputs and for port one under read-select
  function automatic logic [7:0] port_rd(input logic [3:0] n);
    logic [7:0] d;
    logic [7:0] l;
    logic [7:0] p;
    d = dir_q[{n, 3'b000} +: 8];
    l = lat_q[{n, 3'b000} +: 8];
    p = pin_s2_q[{n, 3'b000} +: 8];
    if (n == 4'h1 && p1_sel) begin
      port_rd = l; // RQ13
    end else begin
      port_rd = (d & l) | (~d & p); // RQ8 RQ12 RQ16
    end
  endfunction : port_rd

  // ****************************************************************
  // register file
  // ****************************************************************
  always_comb begin
    dir_d  = dir_q;
    lat_d  = lat_q;
    pu_d   = pu_q;
    pctl_d = pctl_q;
    if (wr_en) begin
      if (in_dir) begin
        for (int b = 0; b < 8; b++) begin
          // bus-owned pins keep their direction in external modes
          if (!lock[{idx, 3'b000} + 7'(b)]) begin // RQ7
            dir_d[{idx, 3'b000} + 7'(b)] = pwdata[b]; // RQ1 RQ6
          end
        end
      end
      if (in_dat) begin
        for (int b = 0; b < 8; b++) begin
          if (!lock[{idx, 3'b000} + 7'(b)]) begin // RQ9
            lat_d[{idx, 3'b000} + 7'(b)] = pwdata[b]; // RQ8
          end
        end
      end
      unique case (paddr)
        pio_pkg::PU0_OFF:  pu_d[7:0]   = pwdata[7:0]; // RQ2
        pio_pkg::PU1_OFF:  pu_d[15:8]  = pwdata[7:0]; // RQ2
        pio_pkg::PU2_OFF:  pu_d[21:16] = pwdata[5:0]; // RQ2
        pio_pkg::PCTL_OFF: pctl_d      = pwdata[pio_pkg::PCTL_P1_RD_BIT];
        default: ;
      endcase
    end
    // no direction storage behind the input-only pin; its latch bit still takes writes
    dir_d[pio_pkg::IN_ONLY_PIN] = 1'b0; // RQ3
  end

  // ****************************************************************
  // apb answer: one wait state, data and error from flops
  // ****************************************************************
  always_comb begin
    rdy_d  = acc && !rdy_q;
    err_d  = 1'b0;
    rdat_d = rdat_q;
    if (acc && !rdy_q) begin
      rdat_d = 32'h0;
      if (in_dir) begin
        rdat_d[7:0] = dir_q[{idx, 3'b000} +: 8];
      end else if (in_dat) begin
        rdat_d[7:0] = port_rd(idx);
      end else begin
        unique case (paddr)
          pio_pkg::PU0_OFF:  rdat_d[7:0] = pu_q[7:0];
          pio_pkg::PU1_OFF:  rdat_d[7:0] = pu_q[15:8];
          pio_pkg::PU2_OFF:  rdat_d[5:0] = pu_q[21:16];
          pio_pkg::PCTL_OFF: rdat_d[pio_pkg::PCTL_P1_RD_BIT] = pctl_q;
          pio_pkg::STAT_OFF: begin
            rdat_d[1:0]                    = mode_s2_q;
            rdat_d[pio_pkg::STAT_BUS8_BIT] = b8_s2_q;
            rdat_d[pio_pkg::STAT_MUX_BIT]  = mux_s2_q;
          end
          default: err_d = 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // pad drive: registered so the pads never see decode glitches
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < pio_pkg::NPIN; i++) begin
      // non-converter peripherals override the direction bit
      pad_d.drv[i]   = periph_oe[i] ? periph_out[i] : lat_q[i]; // RQ4
      pad_d.oen_n[i] = !(periph_oe[i] || dir_q[i]); // RQ4 RQ15
      pad_d.pu[i]    = pu_q[i / 4] && !dir_q[i] // RQ2 RQ10
                       && !(ext && pio_pkg::PU_EXT_OFF_MASK[i / 4]); // RQ11
    end
    pad_d.drv[pio_pkg::IN_ONLY_PIN]   = 1'b0;
    pad_d.oen_n[pio_pkg::IN_ONLY_PIN] = 1'b1; // RQ3
    pad_d.pu[pio_pkg::IN_ONLY_PIN]    = 1'b0; // RQ3
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q       <= pio_pkg::DIR_RST; // RQ15
      lat_q       <= pio_pkg::LAT_RST;
      pu_q        <= pio_pkg::PU_RST;
      pctl_q      <= pio_pkg::PCTL_RST;
      rdy_q       <= 1'b0;
      err_q       <= 1'b0;
      rdat_q      <= 32'h0;
      pad_q.drv   <= 88'h0;
      pad_q.oen_n <= {88{1'b1}};
      pad_q.pu    <= 88'h0;
    end else if (ce) begin
      dir_q  <= dir_d;
      lat_q  <= lat_d;
      pu_q   <= pu_d;
      pctl_q <= pctl_d;
      rdy_q  <= rdy_d;
      err_q  <= err_d;
      rdat_q <= rdat_d;
      pad_q  <= pad_d;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait;
    ce && psel && penable && !rdy_q && !pwrite;
  endsequence

  a_in_only_pin: assert property ( // RQ3
    pad_q.oen_n[pio_pkg::IN_ONLY_PIN] && !pad_q.pu[pio_pkg::IN_ONLY_PIN]
      && !dir_q[pio_pkg::IN_ONLY_PIN])
    else $error("input-only pin drives, pulls up or has a direction");

  a_pu_out_off: assert property ( // RQ10
    ce |=> ((pad_q.pu & $past(dir_q)) == 88'h0))
    else $error("pull-up attached to an output pin");

  a_periph_drive: assert property ( // RQ4
    ce && periph_oe[0] |=> !pad_q.oen_n[0]
      && pad_q.drv[0] == $past(periph_out[0]))
    else $error("peripheral output does not drive its pin");

  a_dir_lock: assert property ( // RQ7
    ce && wr_en && paddr == pio_pkg::DIR_BASE && ext
      |=> dir_q[7:0] == $past(dir_q[7:0]))
    else $error("locked direction bits changed by a write");

  a_lat_lock: assert property ( // RQ9
    ce && wr_en && paddr == pio_pkg::DATA_BASE && ext
      |=> lat_q[7:0] == $past(lat_q[7:0]))
    else $error("locked port latch changed by a write");

  a_ext_pu_off: assert property ( // RQ11
    ce && ext |=> pad_q.pu[35:0] == 36'h0 && pad_q.pu[47:40] == 8'h0)
    else $error("pull-up attached on a bus port in external mode");

  a_p1_latch_rd: assert property ( // RQ13
    s_wait and (paddr == pio_pkg::DATA1_OFF && p1_sel)
      |=> pready && prdata[7:0] == $past(lat_q[15:8]))
    else $error("port one read-select did not return the latch");

  a_p1_pin_rd: assert property ( // RQ12
    s_wait and (paddr == pio_pkg::DATA1_OFF && !p1_sel)
      |=> prdata[7:0] == ($past(dir_q[15:8]) & $past(lat_q[15:8])
        | ~$past(dir_q[15:8]) & $past(pin_s2_q[15:8])))
    else $error("port one read mixes pins and latch wrongly");

  a_port_read: assert property ( // RQ16
    s_wait and (paddr == pio_pkg::DATA_BASE + 12'h024)
      |=> prdata[7:0] == ($past(dir_q[79:72]) & $past(lat_q[79:72])
        | ~$past(dir_q[79:72]) & $past(pin_s2_q[79:72])))
    else $error("port read mixes pins and latch wrongly");

  a_pu_attach: assert property ( // RQ2
    ce |=> pad_q.pu[60] == ($past(pu_q[15]) && !$past(dir_q[60])))
    else $error("enabled pull-up not attached to an input pin");

  a_out_drive: assert property ( // RQ8
    ce |=> pad_q.drv[80] == ($past(periph_oe[80]) ? $past(periph_out[80])
      : $past(lat_q[80])))
    else $error("pin does not drive its latch or peripheral value");

  a_pu_keep: assert property ( // RQ11
    ce && wr_en && ext && paddr == pio_pkg::PU0_OFF
      |=> pu_q[7:0] == $past(pwdata[7:0]))
    else $error("pull-up register not writable in external mode");

  a_dir_write: assert property ( // RQ6
    ce && wr_en && paddr == 12'h024 ##1 1'b1
      |-> dir_q[79:72] == $past(pwdata[7:0]))
    else $error("direction write did not reach its own pins");

endmodule : pio_ports

// ===== pio_pkg.sv
package pio_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NPORT = 11;
  localparam int NPIN  = 88;
  localparam int NGRP  = 22;
  // the one input-only pin: port eight, bit five
  localparam int IN_ONLY_PIN = 69;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] DIR_BASE  = 12'h000;
  localparam logic [11:0] DATA_BASE = 12'h040;
  localparam logic [11:0] PU0_OFF   = 12'h080;
  localparam logic [11:0] PU1_OFF   = 12'h084;
  localparam logic [11:0] PU2_OFF   = 12'h088;
  localparam logic [11:0] PCTL_OFF  = 12'h08C;
  localparam logic [11:0] STAT_OFF  = 12'h090;
  localparam logic [11:0] DATA1_OFF = 12'h044;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          PCTL_P1_RD_BIT = 0;
  localparam int          STAT_BUS8_BIT  = 2;
  localparam int          STAT_MUX_BIT   = 3;
  localparam logic [87:0] DIR_RST        = 88'h0;
  localparam logic [87:0] LAT_RST        = 88'h0;
  localparam logic [21:0] PU_RST         = 22'h0;
  localparam logic        PCTL_RST       = 1'b0;

  // processor modes as seen on the mode pins
  localparam logic [1:0] MODE_SINGLE = 2'h0;

  // pins owned by the external bus in expansion and processor modes
  localparam logic [87:0] BUS_LOCK_MASK = 88'h0000_0000_FFFF_FFFF_FFFF;
  // pull-up groups forced off in expansion and processor modes
  localparam logic [21:0] PU_EXT_OFF_MASK = 22'h00_0DFF;

  // ****************************************************************
  // pad bundle
  // ****************************************************************
  typedef struct packed {
    logic [87:0] drv;
    logic [87:0] oen_n;
    logic [87:0] pu;
  } pio_pad_s;

endpackage : pio_pkg

// ===== pio_pin_model.sv
`timescale 1ns/1ps
module pio_pin_model (
  // pads from the port block
  input  pio_pkg::pio_pad_s  pad,
  // board side
  input  wire logic [87:0]   ext_en,
  input  wire logic [87:0]   ext_drv,
  output logic      [87:0]   pin_in
);
  // ****************************************************************
  // pin resolution
  // ****************************************************************
  // an undriven, unpulled pin shows the inverse of its current pad drive value,
  // so a design that reads a floating pin cannot pass by luck
  always_comb begin
    for (int i = 0; i < 88; i++) begin
      if (!pad.oen_n[i])
        pin_in[i] = pad.drv[i];
      else if (ext_en[i])
        pin_in[i] = ext_drv[i];
      else
        pin_in[i] = pad.pu[i] ? 1'b1 : ~pad.drv[i];
    end
  end
endmodule : pio_pin_model

// ===== tb_programmable_io_ports.sv
`timescale 1ns/1ps
module tb_programmable_io_ports;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, bus_8bit = 0, p1_mux_all = 0, ext = 0;
  logic [1:0] proc_mode = 2'h0;
  logic [87:0] periph_oe = '0, periph_out = '0, pin_in, dir_m, lat_m;
  logic [87:0] ext_drv = '0, ext_en = '1;
  logic [21:0] pu_m;
  logic [31:0] s = 32'hC70A86EA;
  logic pctl_m;
  pio_pkg::pio_pad_s pad, pad_hold;
  int mismatches = 0, tests_run = 0;

  pio_ports DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .proc_mode(proc_mode), .bus_8bit(bus_8bit), .p1_mux_all(p1_mux_all),
    .periph_oe(periph_oe), .periph_out(periph_out), .pin_in(pin_in),
    .pad(pad));
  pio_pin_model PINS (.pad(pad), .ext_en(ext_en), .ext_drv(ext_drv),
    .pin_in(pin_in));

  always #5 pclk = ~pclk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task chk(input logic [87:0] got, input logic [87:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task set_port(input int n, input logic [7:0] d, input logic [7:0] l);
    int p;
    apb(1'b1, pio_pkg::DIR_BASE + 12'(4 * n), {24'h0, d});
    apb(1'b1, pio_pkg::DATA_BASE + 12'(4 * n), {24'h0, l});
    for (int b = 0; b < 8; b++) begin
      p = n * 8 + b;
      if (!(ext && pio_pkg::BUS_LOCK_MASK[p]) && p != 69) begin
        dir_m[p] = d[b];
        lat_m[p] = l[b];
      end
    end
  endtask : set_port

  task chk_pads;
    logic [87:0] eo, ed, ep;
    @(negedge pclk);
    @(negedge pclk);
    eo = ~(dir_m | periph_oe);
    eo[69] = 1'b1;
    ed = (periph_oe & periph_out) | (~periph_oe & lat_m);
    for (int i = 0; i < 88; i++)
      ep[i] = pu_m[i/4] && !dir_m[i] && !(ext && pio_pkg::PU_EXT_OFF_MASK[i/4]);
    ep[69] = 1'b0;
    chk(pad.oen_n, eo);
    chk(pad.drv & ~eo, ed & ~eo);
    chk(pad.pu, ep);
    // hand back on a rising edge so the next drive lands there
    @(posedge pclk);
  endtask : chk_pads

  function logic [7:0] exp_rd(input int n);
    logic [7:0] r;
    for (int b = 0; b < 8; b++)
      r[b] = dir_m[n*8+b] ? lat_m[n*8+b] : ext_drv[n*8+b];
    if (n == 1 && ext && bus_8bit && p1_mux_all && pctl_m)
      r = lat_m[15:8];
    return r;
  endfunction : exp_rd

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    dir_m = '0;
    lat_m = '0;
    pu_m = '0;
    pctl_m = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_pads;
    for (int ps = 0; ps < 2; ps++) begin
      ext = ps[0];
      proc_mode <= ext ? 2'h1 : pio_pkg::MODE_SINGLE;
      repeat (4) @(posedge pclk);
      for (int n = 0; n < 11; n++) begin
        s = lfsr(lfsr(s));
        set_port(n, s[7:0] | (n == 8 ? 8'h20 : 8'h00), s[15:8]);
        ext_drv[n*8 +: 8] <= s[23:16];
      end
      s = lfsr(s);
      pu_m = s[21:0];
      apb(1'b1, pio_pkg::PU0_OFF, {24'h0, pu_m[7:0]});
      apb(1'b1, pio_pkg::PU1_OFF, {24'h0, pu_m[15:8]});
      apb(1'b1, pio_pkg::PU2_OFF, {26'h0, pu_m[21:16]});
      chk_pads;
      periph_out <= {s, s, s[23:0]};
      periph_oe <= {s[23:0], ~s, s};
      chk_pads;
      periph_oe <= '0;
      repeat (4) @(posedge pclk);
      for (int n = 0; n < 11; n++) begin
        apb(1'b0, pio_pkg::DIR_BASE + 12'(4 * n), 32'h0);
        chk(88'(rd), 88'(dir_m[n*8 +: 8]));
        apb(1'b0, pio_pkg::DATA_BASE + 12'(4 * n), 32'h0);
        chk(88'(rd), 88'(exp_rd(n)));
      end
    end
    // enable low: a peripheral takeover must not reach the pads
    @(negedge pclk) pad_hold = pad;
    @(posedge pclk);
    ce <= 1'b0;
    periph_oe <= '1;
    repeat (3) @(posedge pclk);
    @(negedge pclk) chk(pad.oen_n, pad_hold.oen_n);
    @(posedge pclk);
    ce <= 1'b1;
    periph_oe <= '0;
    repeat (4) @(posedge pclk);
    pctl_m = 1'b1;
    apb(1'b1, pio_pkg::PCTL_OFF, 32'h1);
    for (int k = 0; k < 4; k++) begin
      bus_8bit <= k[0];
      p1_mux_all <= k[1];
      repeat (4) @(posedge pclk);
      apb(1'b0, pio_pkg::DATA1_OFF, 32'h0);
      chk(88'(rd), 88'(exp_rd(1)));
    end
    apb(1'b0, 12'hFFC, 32'h0);
    chk(88'({er, rd}), 88'({1'b1, 32'h0}));
    give_verdict;
  end

  initial begin
    #200000;
    mismatches++;
    give_verdict;
  end
endmodule : tb_programmable_io_ports
